// >>> hw/ofm_top.sv
/*
 * Oscillator frequency monitor: APB register slave, key protection,
 * ratio measurement of the oscillator against the reference clock,
 * sticky fault flag and fault reset generation.
 * Assumes both clock inputs arrive as plain pins, sampled by CLK, and
 * that CLK runs faster than twice the oscillator being measured.
 */
`timescale 1ns/1ps
`default_nettype none

module ofm_top (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic CE,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic REF_CLK_IN,
	input wire logic HF_CLK_IN,
	output logic FAULT_RST,
	output logic MON_ACTIVE
);

	// ****************************************
	// Bus decode
	// ****************************************
	ofm_pkg::ofm_apb_req_t req;
	logic setup;
	logic wr;
	logic unlocked;
	logic mapped;
	logic [31:0] rdata_d;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;

	assign req = '{sel: PSEL, enable: PENABLE, write: PWRITE,
		addr: PADDR, wdata: PWDATA};
	// Answer comes in the first access cycle: no wait states
	assign setup = req.sel && !req.enable && !pready_q;
	// Writes land at the access edge where the master sees PREADY
	assign wr = req.sel && req.enable && pready_q && req.write;

	// ****************************************
	// Registers
	// ****************************************
	logic [7:0] key_q;
	logic [7:0] enable_q;
	logic [7:0] lower_q;
	logic [7:0] upper_q;
	logic fault_reset_enable_req_q;
	logic fault_reset_enable_app_q;
	logic mon_app_q;
	logic flag_q;
	logic flag_set;
	logic flag_clr;
	logic wr_key;
	logic wr_en;
	logic wr_ctl;
	logic wr_low;
	logic wr_up;

	assign unlocked = key_q == ofm_pkg::OFM_UNLOCK_CODE;
	assign wr_key = wr && req.addr == ofm_pkg::OFM_ADDR_KEY;
	assign wr_en = wr && req.addr == ofm_pkg::OFM_ADDR_ENABLE && unlocked;
	assign wr_ctl = wr && req.addr == ofm_pkg::OFM_ADDR_RSTCTL && unlocked;
	assign wr_low = wr && req.addr == ofm_pkg::OFM_ADDR_LOWER && unlocked
		&& enable_q != ofm_pkg::OFM_MONITOR_ON_CODE;
	assign wr_up = wr && req.addr == ofm_pkg::OFM_ADDR_UPPER && unlocked
		&& enable_q != ofm_pkg::OFM_MONITOR_ON_CODE;
	assign flag_clr = wr_ctl && req.wdata[ofm_pkg::OFM_FLAG_BIT];

	// Only SYS_RST reaches these; FAULT_RST never loops back here
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			key_q <= ofm_pkg::OFM_LOCK_CODE;
			enable_q <= ofm_pkg::OFM_MONITOR_OFF_CODE;
			lower_q <= ofm_pkg::OFM_LOWER_RESET;
			upper_q <= ofm_pkg::OFM_UPPER_RESET;
			fault_reset_enable_req_q <= 1'b0;
		end
		else if (CE)
		begin
			if (wr_key)
				key_q <= req.wdata[7:0];
			if (wr_en && (req.wdata[7:0] == ofm_pkg::OFM_MONITOR_ON_CODE
				|| req.wdata[7:0] == ofm_pkg::OFM_MONITOR_OFF_CODE))
				enable_q <= req.wdata[7:0];
			if (wr_ctl)
				fault_reset_enable_req_q <= req.wdata[ofm_pkg::OFM_FAULT_RESET_ENABLE_BIT];
			if (wr_low)
				lower_q <= req.wdata[7:0];
			if (wr_up)
				upper_q <= req.wdata[7:0];
		end
	end

	// ****************************************
	// Read mux and bus answer
	// ****************************************
	always_comb
	begin
		rdata_d = 32'h0000_0000;
		mapped = 1'b1;
		unique case (req.addr)
			ofm_pkg::OFM_ADDR_KEY: rdata_d[7:0] = key_q;
			ofm_pkg::OFM_ADDR_ENABLE: rdata_d[7:0] = enable_q;
			ofm_pkg::OFM_ADDR_RSTCTL:
			begin
				rdata_d[ofm_pkg::OFM_FAULT_RESET_ENABLE_BIT] = fault_reset_enable_app_q;
				rdata_d[ofm_pkg::OFM_FLAG_BIT] = flag_q;
			end
			ofm_pkg::OFM_ADDR_LOWER: rdata_d[7:0] = lower_q;
			ofm_pkg::OFM_ADDR_UPPER: rdata_d[7:0] = upper_q;
			default: mapped = 1'b0;
		endcase
	end

	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end
		else if (CE)
		begin
			pready_q <= setup;
			pslverr_q <= setup && !mapped;
			if (setup && !req.write)
				prdata_q <= rdata_d;
		end
	end

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic ref_s1_q;
	logic ref_s2_q;
	logic ref_s3_q;
	logic hf_s1_q;
	logic hf_s2_q;
	logic hf_s3_q;
	logic ref_rise;
	logic hf_rise;

	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			ref_s1_q <= 1'b0;
			ref_s2_q <= 1'b0;
			ref_s3_q <= 1'b0;
			hf_s1_q <= 1'b0;
			hf_s2_q <= 1'b0;
			hf_s3_q <= 1'b0;
		end
		else if (CE)
		begin
			ref_s1_q <= REF_CLK_IN;
			ref_s2_q <= ref_s1_q;
			ref_s3_q <= ref_s2_q;
			hf_s1_q <= HF_CLK_IN;
			hf_s2_q <= hf_s1_q;
			hf_s3_q <= hf_s2_q;
		end
	end

	assign ref_rise = ref_s2_q && !ref_s3_q;
	assign hf_rise = hf_s2_q && !hf_s3_q;

	// ****************************************
	// Settings applied on reference edges
	// ****************************************
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			mon_app_q <= 1'b0;
			fault_reset_enable_app_q <= 1'b0;
		end
		else if (CE && ref_rise)
		begin
			mon_app_q <= enable_q == ofm_pkg::OFM_MONITOR_ON_CODE;
			fault_reset_enable_app_q <= fault_reset_enable_req_q;
		end
	end

	// ****************************************
	// Ratio measurement
	// ****************************************
	logic [1:0] win_q;
	logic [8:0] hf_cnt_q;
	logic win_end;
	logic out_of_range;
	logic hf_bad_q;

	assign win_end = mon_app_q && ref_rise && win_q == ofm_pkg::OFM_WINDOW_LAST;
	assign out_of_range = hf_cnt_q < {1'b0, lower_q}
		|| hf_cnt_q > {1'b0, upper_q};
	assign flag_set = win_end && out_of_range;

	// Counter saturates so a harmonic cannot wrap back into range
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			win_q <= 2'h0;
			hf_cnt_q <= 9'h000;
			hf_bad_q <= 1'b0;
		end
		else if (CE)
		begin
			if (!mon_app_q)
			begin
				win_q <= 2'h0;
				hf_cnt_q <= 9'h000;
				hf_bad_q <= 1'b0;
			end
			else
			begin
				if (ref_rise)
					win_q <= win_q + 2'h1;
				if (win_end)
				begin
					hf_cnt_q <= {8'h00, hf_rise};
					hf_bad_q <= out_of_range;
				end
				else if (hf_rise && hf_cnt_q != 9'h1ff)
					hf_cnt_q <= hf_cnt_q + 9'h001;
			end
		end
	end

	// Set wins over a clear arriving in the same cycle
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
			flag_q <= 1'b0;
		else if (CE)
		begin
			if (flag_set)
				flag_q <= 1'b1;
			else if (flag_clr)
				flag_q <= 1'b0;
		end
	end

	// ****************************************
	// Reference loss watchdog
	// ****************************************
	logic [11:0] ref_idle_q;
	logic ref_lost_q;

	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			ref_idle_q <= 12'h000;
			ref_lost_q <= 1'b0;
		end
		else if (CE)
		begin
			if (ref_rise)
			begin
				ref_idle_q <= 12'h000;
				ref_lost_q <= 1'b0;
			end
			else if (ref_idle_q == 12'(ofm_pkg::OFM_REF_TIMEOUT_CYC))
				ref_lost_q <= 1'b1;
			else
				ref_idle_q <= ref_idle_q + 12'h001;
		end
	end

	// ****************************************
	// Fault reset sequencing
	// ****************************************
	ofm_pkg::ofm_rst_state_t rst_q;
	logic [1:0] edge_q;
	logic rst_arm;

	assign rst_arm = fault_reset_enable_app_q && mon_app_q;

	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			rst_q <= ofm_pkg::OFM_RST_IDLE;
			edge_q <= 2'h0;
		end
		else if (CE)
		begin
			unique case (rst_q)
				ofm_pkg::OFM_RST_IDLE:
				begin
					edge_q <= 2'h0;
					if (rst_arm && ref_lost_q)
						rst_q <= ofm_pkg::OFM_RST_ON;
					else if (rst_arm && flag_set)
						rst_q <= ofm_pkg::OFM_RST_WAIT;
				end
				ofm_pkg::OFM_RST_WAIT:
				begin
					if (!rst_arm)
						rst_q <= ofm_pkg::OFM_RST_IDLE;
					else if (ref_lost_q)
						rst_q <= ofm_pkg::OFM_RST_ON;
					else if (ref_rise)
					begin
						edge_q <= edge_q + 2'h1;
						if (edge_q == ofm_pkg::OFM_ASSERT_EDGE)
							rst_q <= ofm_pkg::OFM_RST_ON;
					end
				end
				ofm_pkg::OFM_RST_ON:
				begin
					// Release after a clean window with reference alive, or at once when rst_arm drops
					if (!rst_arm || (!ref_lost_q && win_end && !out_of_range))
						rst_q <= ofm_pkg::OFM_RST_IDLE;
				end
				default: rst_q <= ofm_pkg::OFM_RST_IDLE;
			endcase
		end
	end

	assign PREADY = pready_q;
	assign PSLVERR = pslverr_q;
	assign PRDATA = prdata_q;
	assign FAULT_RST = rst_q == ofm_pkg::OFM_RST_ON;
	assign MON_ACTIVE = mon_app_q;

	// ****************************************
	// Checks
	// ****************************************
	logic [1:0] lag_q;

	// Reference edges seen while applied reset enable differs from request
	always_ff @(posedge CLK)
	begin
		if (SYS_RST || !CE)
			lag_q <= 2'h0;
		else if (fault_reset_enable_app_q == fault_reset_enable_req_q)
			lag_q <= 2'h0;
		else if (ref_rise && lag_q != 2'h3)
			lag_q <= lag_q + 2'h1;
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	property p_locked_enable;
		CE && wr && !unlocked |=> $stable(enable_q);
	endproperty
	a_locked_enable: assert property (p_locked_enable)
		else $error("enable changed while key locked");

	property p_bad_code;
		CE && wr && req.addr == ofm_pkg::OFM_ADDR_ENABLE
			&& req.wdata[7:0] != ofm_pkg::OFM_MONITOR_ON_CODE
			&& req.wdata[7:0] != ofm_pkg::OFM_MONITOR_OFF_CODE
			|=> $stable(enable_q);
	endproperty
	a_bad_code: assert property (p_bad_code)
		else $error("illegal enable code stored");

	property p_limit_guard;
		CE && enable_q == ofm_pkg::OFM_MONITOR_ON_CODE
			|=> $stable(lower_q) && $stable(upper_q);
	endproperty
	a_limit_guard: assert property (p_limit_guard)
		else $error("limit changed while monitoring");

	property p_flag_sticky;
		CE && flag_q && !flag_clr |=> flag_q;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky)
		else $error("fault flag dropped without clear");

	property p_flag_clear;
		CE && flag_clr && !flag_set |=> !flag_q;
	endproperty
	a_flag_clear: assert property (p_flag_clear)
		else $error("fault flag not cleared");

	property p_second_edge;
		CE && rst_q == ofm_pkg::OFM_RST_WAIT && rst_arm && !ref_lost_q
			&& ref_rise && edge_q == ofm_pkg::OFM_ASSERT_EDGE |=> FAULT_RST;
	endproperty
	a_second_edge: assert property (p_second_edge)
		else $error("fault reset missed second reference edge");

	property p_suppress;
		CE && !rst_arm |=> !FAULT_RST;
	endproperty
	a_suppress: assert property (p_suppress)
		else $error("fault reset while disabled");

	property p_fault_reset_enable_lag;
		lag_q <= 2'h2;
	endproperty
	a_fault_reset_enable_lag: assert property (p_fault_reset_enable_lag)
		else $error("reset enable not applied within two reference edges");

	property p_ref_hold;
		CE && FAULT_RST && ref_lost_q && rst_arm |=> FAULT_RST;
	endproperty
	a_ref_hold: assert property (p_ref_hold)
		else $error("fault reset released while reference stopped");

endmodule : ofm_top

`default_nettype wire

// >>> hw/ofm_pkg.sv
/*
 * Constants and carrier types for the oscillator frequency monitor.
 * Assumes a 25 MHz system clock and an APB master with 32-bit data.
 */
package ofm_pkg;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [11:0] OFM_ADDR_KEY = 12'h000;
	localparam logic [11:0] OFM_ADDR_ENABLE = 12'h004;
	localparam logic [11:0] OFM_ADDR_RSTCTL = 12'h008;
	localparam logic [11:0] OFM_ADDR_LOWER = 12'h010;
	localparam logic [11:0] OFM_ADDR_UPPER = 12'h020;

	// ****************************************
	// Codes and reset values
	// ****************************************
	localparam logic [7:0] OFM_UNLOCK_CODE = 8'hf9;
	localparam logic [7:0] OFM_LOCK_CODE = 8'h06;
	localparam logic [7:0] OFM_MONITOR_ON_CODE = 8'he4;
	localparam logic [7:0] OFM_MONITOR_OFF_CODE = 8'h00;
	localparam logic [7:0] OFM_LOWER_RESET = 8'ha5;
	localparam logic [7:0] OFM_UPPER_RESET = 8'hc9;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int OFM_FLAG_BIT = 0;
	localparam int OFM_FAULT_RESET_ENABLE_BIT = 1;

	// ****************************************
	// Timing
	// ****************************************
	localparam int OFM_CLK_MHZ = 25;
	localparam int OFM_REF_TIMEOUT_US = 100;
	localparam int OFM_REF_TIMEOUT_CYC = OFM_REF_TIMEOUT_US * OFM_CLK_MHZ;
	localparam logic [1:0] OFM_WINDOW_LAST = 2'h3;
	localparam logic [1:0] OFM_ASSERT_EDGE = 2'h1;

	// ****************************************
	// Carrier types
	// ****************************************
	typedef struct packed {
		logic sel;
		logic enable;
		logic write;
		logic [11:0] addr;
		logic [31:0] wdata;
	} ofm_apb_req_t;

	typedef enum logic [1:0] {
		OFM_RST_IDLE = 2'b00,
		OFM_RST_WAIT = 2'b01,
		OFM_RST_ON = 2'b10
	} ofm_rst_state_t;

endpackage : ofm_pkg

// >>> tb/ofm_osc_model.sv
/*
 * Oscillator and reference clock source for the frequency monitor bench.
 * Assumes half periods counted in CLK cycles, set by the bench.
 */
`timescale 1ns/1ps
`default_nettype none

module ofm_osc_model (
	input wire logic CLK,
	input var int ref_half,
	input var int hf_half,
	input var logic ref_run,
	output var logic ref_clk,
	output var logic hf_clk
);
	int ref_cnt = 0;
	int hf_cnt = 0;

	initial
	begin
		ref_clk = 1'b0;
		hf_clk = 1'b0;
	end

	// A stopped reference holds its level, like a dead crystal
	always @(posedge CLK)
	begin
		if (ref_run && ref_cnt >= ref_half - 1)
		begin
			ref_cnt <= 0;
			ref_clk <= ~ref_clk;
		end
		else if (ref_run)
			ref_cnt <= ref_cnt + 1;
		if (hf_cnt >= hf_half - 1)
		begin
			hf_cnt <= 0;
			hf_clk <= ~hf_clk;
		end
		else
			hf_cnt <= hf_cnt + 1;
	end

endmodule : ofm_osc_model

`default_nettype wire

// >>> tb/ofm_tb_top.sv
/*
 * Self-checking bench for the oscillator frequency monitor.
 * Assumes the APB slave answers in the access cycle; reference scaled
 * to 200 CLK per period so a window holds 200 oscillator rises.
 */
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, g) \
	begin \
		cmp_count++; \
		if ((g) !== (e)) \
		begin \
			$display("unexpected %s exp %h got %h", n, e, g); \
			fails++; \
		end \
	end

module ofm_tb_top;
	logic CLK, SYS_RST, CE, PSEL, PENABLE, PWRITE;
	logic [11:0] PADDR;
	logic [31:0] PWDATA, PRDATA, rnd, rd;
	logic PREADY, PSLVERR, ref_clk, hf_clk, FAULT_RST, MON_ACTIVE, err;
	logic ref_run, m_fault_reset_enable, m_flag;
	logic [7:0] m_key, m_en, m_lo, m_hi;
	int ref_half, hf_half, fails, cmp_count, hits, i;
	logic [11:0] addrs [6];

	ofm_top dut (.CLK(CLK), .SYS_RST(SYS_RST), .CE(CE), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
		.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.REF_CLK_IN(ref_clk), .HF_CLK_IN(hf_clk), .FAULT_RST(FAULT_RST),
		.MON_ACTIVE(MON_ACTIVE));

	ofm_osc_model osc (.CLK(CLK), .ref_half(ref_half), .hf_half(hf_half),
		.ref_run(ref_run), .ref_clk(ref_clk), .hf_clk(hf_clk));

	initial
	begin
		CLK = 1'b0;
		forever #20 CLK = ~CLK;
	end

	// ****************************************
	// Model and bus tasks
	// ****************************************
	function automatic logic [31:0] xs();
		rnd = rnd ^ (rnd << 13);
		rnd = rnd ^ (rnd >> 17);
		rnd = rnd ^ (rnd << 5);
		return rnd;
	endfunction : xs

	function automatic logic [31:0] exp_rd(input logic [11:0] a);
		case (a)
			ofm_pkg::OFM_ADDR_KEY: return {24'h0, m_key};
			ofm_pkg::OFM_ADDR_ENABLE: return {24'h0, m_en};
			ofm_pkg::OFM_ADDR_RSTCTL: return {30'h0, m_fault_reset_enable, m_flag};
			ofm_pkg::OFM_ADDR_LOWER: return {24'h0, m_lo};
			ofm_pkg::OFM_ADDR_UPPER: return {24'h0, m_hi};
			default: return 32'h0;
		endcase
	endfunction : exp_rd

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [7:0] d);
		int n;
		logic unl;
		@(posedge CLK);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= {24'h0, d};
		@(posedge CLK);
		PENABLE <= 1'b1;
		n = 0;
		do
		begin
			@(posedge CLK);
			n++;
		end
		while (PREADY !== 1'b1 && n < 16);
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		if (n >= 16)
			fails++;
		unl = (m_key == ofm_pkg::OFM_UNLOCK_CODE);
		if (w)
			case (a)
				ofm_pkg::OFM_ADDR_KEY: m_key = d;
				ofm_pkg::OFM_ADDR_ENABLE:
					if (unl && (d == 8'h00 || d == 8'he4))
						m_en = d;
				ofm_pkg::OFM_ADDR_RSTCTL:
					if (unl)
					begin
						m_fault_reset_enable = d[1];
						if (d[0])
							m_flag = 1'b0;
					end
				ofm_pkg::OFM_ADDR_LOWER:
					if (unl && m_en != 8'he4)
						m_lo = d;
				ofm_pkg::OFM_ADDR_UPPER:
					if (unl && m_en != 8'he4)
						m_hi = d;
				default: ;
			endcase
	endtask : apb

	task automatic rchk(input logic [11:0] a);
		apb(1'b0, a, 8'h00);
		`CHK("prdata", exp_rd(a), rd)
	endtask : rchk

	task automatic poll_fault_reset_enable(input logic v);
		int n;
		n = 0;
		do
		begin
			apb(1'b0, ofm_pkg::OFM_ADDR_RSTCTL, 8'h00);
			n++;
		end
		while (rd[1] !== v && n < 200);
	endtask : poll_fault_reset_enable

	task automatic wait_sig(input int which, input logic v, input int max);
		int n;
		n = 0;
		while ((which == 0 ? MON_ACTIVE : FAULT_RST) !== v && n < max)
		begin
			@(posedge CLK);
			n++;
		end
	endtask : wait_sig

	// Counts cycles with the fault reset up
	task automatic quiet(input int cyc);
		hits = 0;
		repeat (cyc)
		begin
			@(posedge CLK);
			if (FAULT_RST !== 1'b0)
				hits++;
		end
	endtask : quiet

	task automatic do_reset();
		SYS_RST <= 1'b1;
		repeat (5) @(posedge CLK);
		SYS_RST <= 1'b0;
		m_key = 8'h06;
		m_en = 8'h00;
		m_lo = 8'ha5;
		m_hi = 8'hc9;
		m_fault_reset_enable = 1'b0;
		m_flag = 1'b0;
	endtask : do_reset

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test

	// ****************************************
	// Tests
	// ****************************************
	initial
	begin
		SYS_RST = 1'b1;
		CE = 1'b1;
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PADDR = 12'h000;
		PWDATA = 32'h0;
		ref_half = 100;
		hf_half = 2;
		ref_run = 1'b1;
		rnd = 32'd56561;
		fails = 0;
		cmp_count = 0;
		addrs = '{ofm_pkg::OFM_ADDR_KEY, ofm_pkg::OFM_ADDR_ENABLE,
			ofm_pkg::OFM_ADDR_RSTCTL, ofm_pkg::OFM_ADDR_LOWER,
			ofm_pkg::OFM_ADDR_UPPER, 12'h030};
		do_reset();
		for (i = 0; i < 6; i++)
			rchk(addrs[i]);
		`CHK("pslverr", 1'b1, err)
		`CHK("mon_active", 1'b0, MON_ACTIVE)
		$display("test reset values done");
		apb(1'b1, ofm_pkg::OFM_ADDR_ENABLE, 8'he4);
		apb(1'b1, ofm_pkg::OFM_ADDR_LOWER, 8'h11);
		apb(1'b1, ofm_pkg::OFM_ADDR_RSTCTL, 8'h02);
		rchk(ofm_pkg::OFM_ADDR_ENABLE);
		rchk(ofm_pkg::OFM_ADDR_LOWER);
		rchk(ofm_pkg::OFM_ADDR_RSTCTL);
		rnd = xs();
		if (rnd[7:0] == 8'hf9)
			rnd[7:0] = 8'h55;
		apb(1'b1, ofm_pkg::OFM_ADDR_KEY, rnd[7:0]);
		rchk(ofm_pkg::OFM_ADDR_KEY);
		apb(1'b1, ofm_pkg::OFM_ADDR_ENABLE, 8'he4);
		rchk(ofm_pkg::OFM_ADDR_ENABLE);
		$display("test lock done");
		apb(1'b1, ofm_pkg::OFM_ADDR_KEY, 8'hf9);
		apb(1'b1, ofm_pkg::OFM_ADDR_ENABLE, 8'h00);
		rnd = xs();
		if (rnd[7:0] == 8'h00 || rnd[7:0] == 8'he4)
			rnd[7:0] = 8'h5a;
		apb(1'b1, ofm_pkg::OFM_ADDR_ENABLE, rnd[7:0]);
		rchk(ofm_pkg::OFM_ADDR_ENABLE);
		repeat (400) @(posedge CLK);
		apb(1'b1, ofm_pkg::OFM_ADDR_RSTCTL, 8'h03);
		poll_fault_reset_enable(1'b1);
		rchk(ofm_pkg::OFM_ADDR_RSTCTL);
		// Window of 800 CLK sees 200 rises; keep limits clear of it
		rnd = xs();
		apb(1'b1, ofm_pkg::OFM_ADDR_LOWER, {4'ha, rnd[3:0]});
		apb(1'b1, ofm_pkg::OFM_ADDR_UPPER, 8'hd0);
		rchk(ofm_pkg::OFM_ADDR_LOWER);
		rchk(ofm_pkg::OFM_ADDR_UPPER);
		apb(1'b1, ofm_pkg::OFM_ADDR_ENABLE, 8'he4);
		wait_sig(0, 1'b1, 420);
		`CHK("mon_active", 1'b1, MON_ACTIVE)
		apb(1'b1, ofm_pkg::OFM_ADDR_LOWER, 8'h00);
		rchk(ofm_pkg::OFM_ADDR_LOWER);
		apb(1'b1, ofm_pkg::OFM_ADDR_KEY, 8'h06);
		rchk(ofm_pkg::OFM_ADDR_KEY);
		$display("test enable done");
		quiet(2500);
		`CHK("fault_hits", 0, hits)
		rchk(ofm_pkg::OFM_ADDR_RSTCTL);
		hf_half = 4;
		wait_sig(1, 1'b1, 2400);
		`CHK("fault_rst", 1'b1, FAULT_RST)
		m_flag = 1'b1;
		rchk(ofm_pkg::OFM_ADDR_RSTCTL);
		hf_half = 2;
		wait_sig(1, 1'b0, 2500);
		`CHK("fault_rst", 1'b0, FAULT_RST)
		rchk(ofm_pkg::OFM_ADDR_RSTCTL);
		rchk(ofm_pkg::OFM_ADDR_LOWER);
		apb(1'b1, ofm_pkg::OFM_ADDR_KEY, 8'hf9);
		apb(1'b1, ofm_pkg::OFM_ADDR_RSTCTL, 8'h02);
		rchk(ofm_pkg::OFM_ADDR_RSTCTL);
		apb(1'b1, ofm_pkg::OFM_ADDR_RSTCTL, 8'h03);
		rchk(ofm_pkg::OFM_ADDR_RSTCTL);
		$display("test fault done");
		ref_run = 1'b0;
		wait_sig(1, 1'b1, 2700);
		`CHK("fault_rst", 1'b1, FAULT_RST)
		ref_run = 1'b1;
		wait_sig(1, 1'b0, 2500);
		`CHK("fault_rst", 1'b0, FAULT_RST)
		// Window stretched by the stop saturates the count: flag sets
		m_flag = 1'b1;
		rchk(ofm_pkg::OFM_ADDR_RSTCTL);
		$display("test reference loss done");
		apb(1'b1, ofm_pkg::OFM_ADDR_ENABLE, 8'h00);
		wait_sig(0, 1'b0, 420);
		`CHK("mon_active", 1'b0, MON_ACTIVE)
		apb(1'b1, ofm_pkg::OFM_ADDR_RSTCTL, 8'h01);
		poll_fault_reset_enable(1'b0);
		rchk(ofm_pkg::OFM_ADDR_RSTCTL);
		apb(1'b1, ofm_pkg::OFM_ADDR_ENABLE, 8'he4);
		wait_sig(0, 1'b1, 420);
		hf_half = 4;
		quiet(2400);
		`CHK("fault_hits", 0, hits)
		m_flag = 1'b1;
		rchk(ofm_pkg::OFM_ADDR_RSTCTL);
		hf_half = 2;
		$display("test suppressed reset done");
		do_reset();
		for (i = 0; i < 5; i++)
			rchk(addrs[i]);
		$display("test second reset done");
		finish_test();
	end

	initial
	begin
		#(40 * 60000);
		fails++;
		finish_test();
	end

endmodule : ofm_tb_top

`default_nettype wire
